/* design/prs_sequencer.sv */
`timescale 1ns/1ps
module prs_sequencer #(
  parameter int PARK_CYCLES = prs_pkg::PARK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_good_in,
  input wire logic power_on_sense_in,
  input wire logic standby_ctrl_in,
  input wire logic addr_sel_in,
  input wire logic gpio_out_val,
  input wire logic gpio_out_en,
  input wire logic load_done,
  input wire logic host_bus_clock_in,
  input wire logic host_bus_data_in,
  input wire logic peripheral_bus_clock_in,
  input wire logic peripheral_bus_data_in,
  input wire prs_pkg::prs_bus_drive_type host_drive_req,
  input wire prs_pkg::prs_bus_drive_type periph_drive_req,
  output logic addr_sel_out,
  output logic addr_sel_oe_n,
  output logic park_req,
  output logic ctrl_reset,
  output logic load_start,
  output logic powered_indicator_out,
  output logic init_complete_gpio,
  output logic active_mode,
  output logic [6:0] slave_addr_write,
  output logic [6:0] slave_addr_read,
  output prs_pkg::prs_status_type status,
  output prs_pkg::prs_bus_drive_type host_bus_drive,
  output prs_pkg::prs_bus_drive_type peripheral_bus_drive,
  output logic [3:0] host_bus_sampled
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pg_sync_q;
  logic [2:0] ps_sync_q;
  logic [2:0] sb_sync_q;
  logic [2:0] as_sync_q;
  logic pg_q;
  logic ps_q;
  logic sb_q;
  logic as_q;

  // Three stages; a level counts once the last two agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pg_sync_q <= 3'h0;
      ps_sync_q <= 3'h0;
      sb_sync_q <= 3'h0;
      as_sync_q <= 3'h0;
    end
    else
    begin
      pg_sync_q <= {pg_sync_q[1:0], power_good_in};
      ps_sync_q <= {ps_sync_q[1:0], power_on_sense_in};
      sb_sync_q <= {sb_sync_q[1:0], standby_ctrl_in};
      as_sync_q <= {as_sync_q[1:0], addr_sel_in};
    end
  end

  // Agreed levels, held on disagreement
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pg_q <= 1'b0;
      ps_q <= 1'b0;
      sb_q <= 1'b0;
      as_q <= 1'b0;
    end
    else
    begin
      if (pg_sync_q[2] == pg_sync_q[1]) pg_q <= pg_sync_q[2];
      if (ps_sync_q[2] == ps_sync_q[1]) ps_q <= ps_sync_q[2];
      if (sb_sync_q[2] == sb_sync_q[1]) sb_q <= sb_sync_q[2];
      if (as_sync_q[2] == as_sync_q[1]) as_q <= as_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Power-good filter
  // ----------------------------------------------------------------
  logic [9:0] pg_cnt_q;
  logic pg_ok_q;

  // Asymmetric qualify: long low to drop, shorter high to accept
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pg_cnt_q <= 10'h000;
      pg_ok_q <= 1'b0;
    end
    else if (pg_q == pg_ok_q)
      pg_cnt_q <= 10'h000; // Glitch shorter than limit dies here
    else if (!pg_ok_q && pg_cnt_q >= 10'(prs_pkg::PG_HIGH_CYCLES - 1))
    begin
      pg_ok_q <= 1'b1;
      pg_cnt_q <= 10'h000;
    end
    else if (pg_ok_q && pg_cnt_q >= 10'(prs_pkg::PG_LOW_CYCLES - 1))
    begin
      pg_ok_q <= 1'b0;
      pg_cnt_q <= 10'h000;
    end
    else
      pg_cnt_q <= pg_cnt_q + 10'h001;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  prs_pkg::prs_state_type state_q;
  logic [15:0] cnt_q;
  logic [15:0] mem_q [prs_pkg::MEM_WORDS];
  logic mem_pass_q;
  logic mem_fail_q;
  logic addr_high_q;
  logic run_ok;
  logic mem_bad;

  // Test word per index; the index in the low bits catches address faults
  function automatic logic [15:0] mem_pattern(input logic [3:0] idx);
    mem_pattern = {12'hA5C, idx};
  endfunction : mem_pattern

  // Read-pass mismatch, seen now so that a fault in the last word still halts
  assign mem_bad = (state_q == prs_pkg::PRS_MEMTEST) && (cnt_q >= 16'(prs_pkg::MEM_WORDS)) &&
                   (mem_q[cnt_q[3:0]] != mem_pattern(cnt_q[3:0]));

  // Sense drops only when supplies really fail, so it also resets us
  assign run_ok = pg_ok_q && ps_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= prs_pkg::PRS_OFF;
      cnt_q <= 16'h0000;
    end
    else if (!run_ok && state_q != prs_pkg::PRS_OFF && state_q != prs_pkg::PRS_PARK
             && state_q != prs_pkg::PRS_RESET)
    begin
      state_q <= prs_pkg::PRS_PARK; // Park first, reset after
      cnt_q <= 16'h0000;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      unique case (state_q)
        prs_pkg::PRS_OFF, prs_pkg::PRS_RESET:
          if (run_ok) // Stay in reset while power-good low
          begin
            state_q <= prs_pkg::PRS_MEMTEST;
            cnt_q <= 16'h0000;
          end
        prs_pkg::PRS_PARK:
          if (cnt_q >= 16'(PARK_CYCLES - 1))
            state_q <= prs_pkg::PRS_RESET;
        prs_pkg::PRS_MEMTEST:
          // Write pass then read pass over the array
          if (cnt_q == 16'(2 * prs_pkg::MEM_WORDS - 1))
          begin
            cnt_q <= 16'h0000;
            state_q <= (mem_fail_q || mem_bad) ? prs_pkg::PRS_ERR_P1 :
                       prs_pkg::PRS_LOAD;
          end
        prs_pkg::PRS_LOAD:
          if (load_done)
          begin
            state_q <= prs_pkg::PRS_LEAD;
            cnt_q <= 16'h0000;
          end
        prs_pkg::PRS_LEAD:
          if (cnt_q >= 16'(prs_pkg::LEAD_CYCLES - 1))
            state_q <= prs_pkg::PRS_DONE;
        prs_pkg::PRS_DONE:
          state_q <= prs_pkg::PRS_DONE;
        prs_pkg::PRS_ERR_P1, prs_pkg::PRS_ERR_GAP, prs_pkg::PRS_ERR_P2:
          if (cnt_q >= 16'(prs_pkg::PULSE_CYCLES - 1))
          begin
            cnt_q <= 16'h0000;
            state_q <= (state_q == prs_pkg::PRS_ERR_P1) ? prs_pkg::PRS_ERR_GAP :
                       (state_q == prs_pkg::PRS_ERR_GAP) ? prs_pkg::PRS_ERR_P2 :
                       prs_pkg::PRS_HALT;
          end
        prs_pkg::PRS_HALT:
          state_q <= prs_pkg::PRS_HALT;
        default:
          state_q <= prs_pkg::PRS_OFF;
      endcase
    end
  end

  // Memory init and march test; pattern depends on the index
  always_ff @(posedge clk)
  begin
    if (state_q == prs_pkg::PRS_MEMTEST && cnt_q < 16'(prs_pkg::MEM_WORDS))
      mem_q[cnt_q[3:0]] <= mem_pattern(cnt_q[3:0]);
  end

  // Result recorded in status
  always_ff @(posedge clk)
  begin
    if (reset || state_q == prs_pkg::PRS_RESET || state_q == prs_pkg::PRS_OFF)
    begin
      mem_pass_q <= 1'b0;
      mem_fail_q <= 1'b0;
    end
    else if (state_q == prs_pkg::PRS_MEMTEST && cnt_q >= 16'(prs_pkg::MEM_WORDS))
    begin
      if (mem_bad)
        mem_fail_q <= 1'b1;
      if (cnt_q == 16'(2 * prs_pkg::MEM_WORDS - 1))
        mem_pass_q <= !mem_fail_q && !mem_bad;
    end
  end

  // Address strap caught at power-up, kept afterwards
  always_ff @(posedge clk)
  begin
    if (reset)
      addr_high_q <= 1'b0;
    else if (state_q == prs_pkg::PRS_OFF || state_q == prs_pkg::PRS_RESET)
      addr_high_q <= as_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      active_mode <= 1'b0;
      powered_indicator_out <= 1'b0;
      init_complete_gpio <= 1'b0;
    end
    else
    begin
      active_mode <= run_ok && sb_q;
      powered_indicator_out <= (state_q == prs_pkg::PRS_LEAD) ||
                               (state_q == prs_pkg::PRS_DONE);
      init_complete_gpio <= (state_q == prs_pkg::PRS_DONE) ||
                            (state_q == prs_pkg::PRS_ERR_P1) ||
                            (state_q == prs_pkg::PRS_ERR_P2);
    end
  end

  assign park_req = (state_q == prs_pkg::PRS_PARK);
  assign ctrl_reset = (state_q == prs_pkg::PRS_OFF) || (state_q == prs_pkg::PRS_PARK) ||
                      (state_q == prs_pkg::PRS_RESET);
  assign load_start = (state_q == prs_pkg::PRS_LOAD);
  assign slave_addr_write = addr_high_q ? prs_pkg::ADDR_HIGH_WRITE : prs_pkg::ADDR_LOW_WRITE;
  assign slave_addr_read = addr_high_q ? prs_pkg::ADDR_HIGH_READ : prs_pkg::ADDR_LOW_READ;
  assign status = '{mem_fail: mem_fail_q, mem_pass: mem_pass_q,
                    active_mode: active_mode, addr_high: addr_high_q};

  // Pin is input until init is done, then a GPIO
  assign addr_sel_out = gpio_out_val;
  assign addr_sel_oe_n = !(state_q == prs_pkg::PRS_DONE && init_complete_gpio && gpio_out_en);

  // Bus engines sit outside; held off the pins during reset
  assign host_bus_drive = ctrl_reset ? 4'hF : host_drive_req;
  assign peripheral_bus_drive = ctrl_reset ? 4'hF : periph_drive_req;
  assign host_bus_sampled = {host_bus_clock_in, host_bus_data_in,
                             peripheral_bus_clock_in, peripheral_bus_data_in};

endmodule : prs_sequencer

/* design/prs_pkg.sv */
package prs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int PG_LOW_MIN_NS = 4000;
  localparam int PG_HIGH_MIN_NS = 625;
  localparam int PG_LOW_CYCLES = (PG_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PG_HIGH_CYCLES = (PG_HIGH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PARK_CYCLES_DEF = 64;
  localparam int MEM_WORDS = 16;
  localparam int PULSE_CYCLES = 8;
  localparam int LEAD_CYCLES = 4;

  // ----------------------------------------------------------------
  // Slave addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_LOW_WRITE = 7'h34;
  localparam logic [6:0] ADDR_LOW_READ = 7'h35;
  localparam logic [6:0] ADDR_HIGH_WRITE = 7'h3A;
  localparam logic [6:0] ADDR_HIGH_READ = 7'h3B;

  typedef enum logic [3:0] {
    PRS_OFF,
    PRS_PARK,
    PRS_RESET,
    PRS_MEMTEST,
    PRS_LOAD,
    PRS_LEAD,
    PRS_DONE,
    PRS_ERR_P1,
    PRS_ERR_GAP,
    PRS_ERR_P2,
    PRS_HALT
  } prs_state_type;

  // Status word seen by the host
  typedef struct packed {
    logic mem_fail;
    logic mem_pass;
    logic active_mode;
    logic addr_high;
  } prs_status_type;

  // One two-wire bus, open drain, oe low drives low
  typedef struct packed {
    logic clk_out;
    logic clk_oe_n;
    logic data_out;
    logic data_oe_n;
  } prs_bus_drive_type;

endpackage : prs_pkg

/* sim/prs_sequencer_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Power and start-up checks
// ----------------------------------------
module prs_sequencer_props #(
  parameter int PARK_CYCLES = prs_pkg::PARK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_good_in,
  input wire logic standby_ctrl_in,
  input wire logic park_req,
  input wire logic ctrl_reset,
  input wire logic load_start,
  input wire logic powered_indicator_out,
  input wire logic init_complete_gpio,
  input wire logic active_mode,
  input wire logic addr_sel_oe_n,
  input wire logic [6:0] slave_addr_write,
  input wire logic [6:0] slave_addr_read,
  input wire prs_pkg::prs_status_type status,
  input wire prs_pkg::prs_bus_drive_type host_bus_drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  int lo_q;
  int hi_q;
  int park_q;
  // Run lengths of the raw input and the park phase
  always_ff @(posedge clk)
  begin
    lo_q <= power_good_in ? 0 : lo_q + 1;
    hi_q <= power_good_in ? hi_q + 1 : 0;
    park_q <= park_req ? park_q + 1 : 0;
  end
  property p_park;
    $fell(park_req) |-> park_q == PARK_CYCLES && ctrl_reset;
  endproperty
  a_park: assert property (p_park) else $error("park phase wrong");
  property p_glitch;
    $rose(park_req) |-> lo_q >= prs_pkg::PG_LOW_CYCLES;
  endproperty
  a_glitch: assert property (p_glitch) else $error("park on short dip");
  property p_hold;
    ctrl_reset && !power_good_in |=> ctrl_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("reset left while input low");
  property p_accept;
    $fell(ctrl_reset) |-> hi_q >= prs_pkg::PG_HIGH_CYCLES;
  endproperty
  a_accept: assert property (p_accept) else $error("input accepted too soon");
  property p_mode;
    (!ctrl_reset && $stable(standby_ctrl_in)) [*8] |-> active_mode == standby_ctrl_in;
  endproperty
  a_mode: assert property (p_mode) else $error("mode not following input");
  property p_lead;
    $rose(powered_indicator_out) |-> !init_complete_gpio ##4 $rose(init_complete_gpio);
  endproperty
  a_lead: assert property (p_lead) else $error("indicator lead wrong");
  property p_load;
    $rose(load_start) |-> status.mem_pass;
  endproperty
  a_load: assert property (p_load) else $error("load before memory pass");
  property p_halt;
    status.mem_fail |-> !load_start;
  endproperty
  a_halt: assert property (p_halt) else $error("load after memory fail");
  property p_addr;
    slave_addr_write == (status.addr_high ? 7'h3A : 7'h34)
      && slave_addr_read == (status.addr_high ? 7'h3B : 7'h35);
  endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");
  property p_gpio;
    !addr_sel_oe_n |-> init_complete_gpio;
  endproperty
  a_gpio: assert property (p_gpio) else $error("select pin driven early");
  property p_bus;
    ctrl_reset |-> host_bus_drive == 4'hF;
  endproperty
  a_bus: assert property (p_bus) else $error("bus driven in reset");
  c_init: cover property ($rose(init_complete_gpio));
  c_park: cover property ($rose(park_req));
  c_gpio: cover property ($fell(addr_sel_oe_n));
endmodule : prs_sequencer_props

bind prs_sequencer prs_sequencer_props #(.PARK_CYCLES(PARK_CYCLES)) prs_sequencer_props_inst (
  .clk(clk), .reset(reset), .power_good_in(power_good_in),
  .standby_ctrl_in(standby_ctrl_in), .park_req(park_req), .ctrl_reset(ctrl_reset),
  .load_start(load_start), .powered_indicator_out(powered_indicator_out),
  .init_complete_gpio(init_complete_gpio), .active_mode(active_mode),
  .addr_sel_oe_n(addr_sel_oe_n), .slave_addr_write(slave_addr_write),
  .slave_addr_read(slave_addr_read), .status(status), .host_bus_drive(host_bus_drive)
);

/* sim/prs_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Supply monitor model
// ----------------------------------------
module prs_monitor #(
  parameter int WARN = 600
) (
  input wire logic clk,
  input wire logic supply_on,
  input wire logic dip,
  output logic power_good_in,
  output logic power_on_sense_in
);
  int warn_q = 0;
  initial power_good_in = 1'b0;
  initial power_on_sense_in = 1'b0;
  // Warning drops first; sense holds through the shortened warning span
  always @(negedge clk)
  begin
    power_good_in <= supply_on && !dip;
    warn_q <= supply_on ? WARN : (warn_q > 0 ? warn_q - 1 : 0);
    power_on_sense_in <= supply_on || warn_q > 1;
  end
endmodule : prs_monitor

/* sim/prs_sequencer_test.sv */
`timescale 1ns/1ps
module prs_sequencer_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic supply_on = 1'b0;
  logic dip = 1'b0;
  logic standby = 1'b1;
  logic sel = 1'b0;
  logic gpio_en = 1'b0;
  logic load_done = 1'b0;
  logic [3:0] pins = 4'hA;
  prs_pkg::prs_bus_drive_type req = 4'h5;
  logic pg;
  logic sense;
  logic sel_out;
  logic sel_oe_n;
  logic park;
  logic creset;
  logic load_start;
  logic powered;
  logic init;
  logic active;
  logic [6:0] wr;
  logic [6:0] rd;
  prs_pkg::prs_status_type status;
  prs_pkg::prs_bus_drive_type hdrv;
  prs_pkg::prs_bus_drive_type pdrv;
  logic [3:0] sampled;
  int n_fail = 0;
  int cmp_count = 0;
  // Oscillator runs from time zero, settled long before sense rises
  always #5 clk = ~clk;
  // Flash side answers half a cycle after the load request, on the next falling edge
  always @(negedge clk) load_done <= load_start;
  prs_monitor prs_monitor_inst (.clk(clk), .supply_on(supply_on), .dip(dip),
    .power_good_in(pg), .power_on_sense_in(sense));
  prs_sequencer #(.PARK_CYCLES(4)) prs_sequencer_inst (.clk(clk), .reset(reset),
    .power_good_in(pg), .power_on_sense_in(sense), .standby_ctrl_in(standby),
    .addr_sel_in(sel), .gpio_out_val(1'b1), .gpio_out_en(gpio_en), .load_done(load_done),
    .host_bus_clock_in(pins[3]), .host_bus_data_in(pins[2]),
    .peripheral_bus_clock_in(pins[1]), .peripheral_bus_data_in(pins[0]),
    .host_drive_req(req), .periph_drive_req(req), .addr_sel_out(sel_out),
    .addr_sel_oe_n(sel_oe_n), .park_req(park), .ctrl_reset(creset), .load_start(load_start),
    .powered_indicator_out(powered), .init_complete_gpio(init), .active_mode(active),
    .slave_addr_write(wr), .slave_addr_read(rd), .status(status), .host_bus_drive(hdrv),
    .peripheral_bus_drive(pdrv), .host_bus_sampled(sampled));
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic power_up(input logic s, input logic [6:0] w, input logic [6:0] r);
    sel = s;
    supply_on = 1'b1;
    for (int i = 0; i < 3000 && powered !== 1'b1; i++) @(negedge clk);
    check("init early", init, 0);
    repeat (4) @(negedge clk);
    check("init", init, 1);
    check("mem pass", status.mem_pass, 1);
    check("load idle", load_start, 0);
    check("write addr", wr, w);
    check("read addr", rd, r);
    check("addr high", status.addr_high, s);
    $display("power up done");
  endtask : power_up
  task automatic glitch_and_pins;
    logic parked;
    parked = 1'b0;
    dip = 1'b1;
    // Watch park through the dip and after it, so a quick recovery cannot hide it
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk);
      if (i == 299)
      begin
        dip = 1'b0;
        pins = 4'h6;
      end
      parked = parked | park;
    end
    check("park on dip", parked, 0);
    check("init after dip", init, 1);
    check("sampled", sampled, 4'h6);
    check("host drive", hdrv, req);
    check("periph drive", pdrv, req);
    $display("glitch done");
  endtask : glitch_and_pins
  task automatic mode_and_gpio;
    standby = 1'b0;
    gpio_en = 1'b1;
    repeat (12) @(negedge clk);
    check("standby", active, 0);
    check("status mode", status.active_mode, 0);
    check("pin oe", sel_oe_n, 0);
    check("pin value", sel_out, 1);
    standby = 1'b1;
    gpio_en = 1'b0;
    repeat (12) @(negedge clk);
    check("active", active, 1);
    check("pin off", sel_oe_n, 1);
    $display("mode done");
  endtask : mode_and_gpio
  task automatic power_loss;
    supply_on = 1'b0;
    for (int i = 0; i < 1000 && park !== 1'b1; i++) @(negedge clk);
    check("park", park, 1);
    repeat (8) @(negedge clk);
    check("reset after park", creset, 1);
    check("bus released", hdrv, 4'hF);
    repeat (200) @(negedge clk);
    check("held", creset, 1);
    check("init low", init, 0);
    $display("power loss done");
  endtask : power_loss
  initial
  begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("reset out", creset, 1);
    power_up(1'b0, 7'h34, 7'h35);
    glitch_and_pins();
    mode_and_gpio();
    power_loss();
    power_up(1'b1, 7'h3A, 7'h3B);
    stop_test();
  end
  // Hang guard, well past the expected thirteen hundred or so cycles
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule : prs_sequencer_test
